// ---- uirq_top.sv ----
// uirq_top: interrupt mask, identification, line status and dma
// ready pins of one uart channel.
// assumes a one-cycle access strobe on the parallel port and fifo
// counts and line events supplied by the channel's datapath.
//
// Behaviour
// - cts rising edge raises an interrupt while its enable is set
// - rts output rising edge raises an interrupt while enabled
// - received xoff raises an interrupt only while enabled
// - mask bit 4 enables or disables sleep mode
// - modem status change interrupts only while enabled
// - receive line status conditions interrupt only while enabled
// - transmit holding empty interrupts while enabled, matching status
// - fifo mode receive interrupt follows count versus trigger level
// - reset clears every interrupt enable and sleep enable
// - identification shows receive trigger and clears with it
// - data ready sets on a loaded character, clears when empty
// - with fifo on and all interrupt enables off, status is polled
// - line status bits 1 to 4 report receive error kinds
// - line status bit 5 set while transmit fifo is empty
// - bit 6 set when transmit fifo and shift register empty
// - bit 7 set when any received character carries an error
// - mode 0 transmit request goes low when holding space is free
// - mode 0 receive request goes low when a character is loaded
// - interrupt on channel pin in 16 mode, wire-or pin in 68
// - mask bits 4 to 7 accessible only with enhanced features on
// - mode 0 transmit request returns high after first write
// - mode 0 receive request returns high when receiver empties
`timescale 1ns/10ps
module uirq_top
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // parallel register port
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // configuration levels
  input wire logic i_mode68,
  input wire logic i_enh_en,
  // line events and datapath status
  input wire logic i_cts,
  input wire logic i_rts,
  input wire logic i_xoff_rx,
  input wire logic i_msr_delta,
  input wire logic [3:0] i_rx_err,
  input wire logic i_rx_fifo_err,
  input wire logic [6:0] i_rx_count,
  input wire logic [6:0] i_rx_trig,
  input wire logic i_tx_fifo_empty,
  input wire logic i_tsr_empty,
  // outputs
  output logic o_chan_irq_out,
  output logic o_irq_wor_o,
  output logic o_irq_wor_oe,
  output logic o_tx_dma_req_n,
  output logic o_rx_dma_req_n,
  output logic o_sleep_en,
  output logic o_fifo_en,
  output logic o_dma_mode
);

  // =========================================================
  // declarations
  logic [7:0] imask_r;
  logic [7:0] fctl_r;
  logic [7:0] rdata_nxt;
  logic wr_stb;
  logic rd_stb;
  logic hold_wr;
  logic ident_rd;
  logic lstat_rd;
  logic imask_wr;
  logic [7:0] imask_nxt;
  logic [uirq_pkg::EV_W-1:0] ev_lvl;
  logic [uirq_pkg::EV_W-1:0] ev_clr;
  logic [uirq_pkg::EV_W-1:0] ev_flag;
  logic [7:0] lsr;
  logic rx_ready;
  logic thr_empty;
  logic rls_pend;
  logic [7:0] pend;
  logic [7:0] ident;
  logic irq_any;
  uirq_pkg::uirq_txreq_t txq_r;
  uirq_pkg::uirq_txreq_t txq_nxt;

  uirq_lsr_if lsif ();

  // =========================================================
  // strobe decode, one access per selected cycle
  assign wr_stb = !i_cs_n && !i_wr_n;
  assign rd_stb = !i_cs_n && !i_rd_n;
  assign hold_wr = wr_stb && (i_addr == uirq_pkg::OFS_HOLD);
  assign imask_wr = wr_stb && (i_addr == uirq_pkg::OFS_IMASK);
  assign ident_rd = rd_stb && (i_addr == uirq_pkg::OFS_FIFO);
  assign lstat_rd = rd_stb && (i_addr == uirq_pkg::OFS_LSTAT);

  // =========================================================
  // identification code of the highest pending source
  function automatic logic [7:0] id_code(input logic [7:0] p);
    logic [7:0] c;
    c = uirq_pkg::ID_NONE;
    if (p[uirq_pkg::IM_RLS])
      c = uirq_pkg::ID_RLS;
    else if (p[uirq_pkg::IM_RX_DMA_REQ_N])
      c = uirq_pkg::ID_RX_DMA_REQ_N;
    else if (p[uirq_pkg::IM_THRE])
      c = uirq_pkg::ID_THRE;
    else if (p[uirq_pkg::IM_MSR])
      c = uirq_pkg::ID_MSR;
    else if (p[uirq_pkg::IM_XOFF])
      c = uirq_pkg::ID_XOFF;
    else if (p[uirq_pkg::IM_CTS] || p[uirq_pkg::IM_RTS])
      c = uirq_pkg::ID_FLOW;
    return c;
  endfunction

  // =========================================================
  // mask write, upper half guarded by enhanced enable
  always_comb
  begin
    imask_nxt = imask_r;
    if (imask_wr)
    begin
      if (i_enh_en)
        imask_nxt = i_wdata;
      else
        imask_nxt = (imask_r & ~uirq_pkg::IM_LOW_MASK)
          | (i_wdata & uirq_pkg::IM_LOW_MASK);
    end
  end

  // mask register, all enables cleared at reset
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      imask_r <= uirq_pkg::IMASK_RST;
    else
      imask_r <= imask_nxt;

  // =========================================================
  // fifo control, reset bits do not stay set
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      fctl_r <= uirq_pkg::FCTL_RST;
    else if (wr_stb && (i_addr == uirq_pkg::OFS_FIFO))
      fctl_r <= i_wdata & uirq_pkg::FC_KEEP;

  // =========================================================
  // flow control and xoff events, cleared by identification read
  assign ev_lvl[uirq_pkg::EV_CTS] = i_cts;
  assign ev_lvl[uirq_pkg::EV_RTS] = i_rts;
  assign ev_lvl[uirq_pkg::EV_XOFF] = i_xoff_rx;
  assign ev_clr = {uirq_pkg::EV_W{ident_rd}};

  uirq_edge #(
    .W(uirq_pkg::EV_W)
  ) u_edge (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_lvl(ev_lvl),
    .i_clr(ev_clr),
    .o_flag(ev_flag)
  );

  // =========================================================
  // line status keeper
  assign lsif.err_set = i_rx_err;
  assign lsif.rd_clr = lstat_rd;
  assign lsif.data_rdy = (i_rx_count != 7'h00);
  assign lsif.tx_empty = i_tx_fifo_empty;
  assign lsif.tsr_empty = i_tsr_empty;
  assign lsif.fifo_err = i_rx_fifo_err;
  assign lsr = lsif.lsr;

  uirq_lsr u_lsr (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .ls(lsif.stat)
  );

  // =========================================================
  // raw source conditions
  // receive ready uses the trigger level with fifos on, else any data
  assign rx_ready = fctl_r[uirq_pkg::FC_FIFO_EN]
    ? (i_rx_count >= i_rx_trig)
    : (i_rx_count != 7'h00);
  assign thr_empty = lsr[uirq_pkg::LS_THRE];
  assign rls_pend = |lsr[uirq_pkg::LS_ERR_LO +: 4];

  // pending sources gated by their enables
  always_comb
  begin
    pend = 8'h00;
    pend[uirq_pkg::IM_RX_DMA_REQ_N] = rx_ready
      & imask_r[uirq_pkg::IM_RX_DMA_REQ_N];
    pend[uirq_pkg::IM_THRE] = thr_empty
      & imask_r[uirq_pkg::IM_THRE];
    pend[uirq_pkg::IM_RLS] = rls_pend
      & imask_r[uirq_pkg::IM_RLS];
    pend[uirq_pkg::IM_MSR] = i_msr_delta
      & imask_r[uirq_pkg::IM_MSR];
    pend[uirq_pkg::IM_XOFF] = ev_flag[uirq_pkg::EV_XOFF]
      & imask_r[uirq_pkg::IM_XOFF];
    pend[uirq_pkg::IM_RTS] = ev_flag[uirq_pkg::EV_RTS]
      & imask_r[uirq_pkg::IM_RTS];
    pend[uirq_pkg::IM_CTS] = ev_flag[uirq_pkg::EV_CTS]
      & imask_r[uirq_pkg::IM_CTS];
  end

  // with all enables cleared nothing here fires: polled mode
  assign irq_any = |pend;

  // identification word, fifo flags on top when fifos enabled
  assign ident = id_code(pend)
    | (fctl_r[uirq_pkg::FC_FIFO_EN] ? uirq_pkg::ID_FIFO_ON : 8'h00);

  // =========================================================
  // interrupt outputs, routed by bus mode
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      o_chan_irq_out <= 1'b0;
    else
      o_chan_irq_out <= irq_any && !i_mode68;

  // wire-or request pulls low while an interrupt is pending in 68 mode
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      o_irq_wor_oe <= 1'b0;
    else
      o_irq_wor_oe <= irq_any && i_mode68;

  // open-drain line only ever drives low
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      o_irq_wor_o <= 1'b0;
    else
      o_irq_wor_o <= 1'b0;

  // =========================================================
  // register read data, returned one cycle after the strobe
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (i_addr)
      uirq_pkg::OFS_IMASK:
        rdata_nxt = i_enh_en ? imask_r
          : (imask_r & uirq_pkg::IM_LOW_MASK);
      uirq_pkg::OFS_FIFO:
        rdata_nxt = ident;
      uirq_pkg::OFS_LSTAT:
        rdata_nxt = lsr;
      default:
        rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      o_rdata <= 8'h00;
    else if (rd_stb)
      o_rdata <= rdata_nxt;

  // =========================================================
  // control level outputs
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      o_sleep_en <= 1'b0;
      o_fifo_en <= 1'b0;
      o_dma_mode <= 1'b0;
    end
    else
    begin
      o_sleep_en <= imask_r[uirq_pkg::IM_SLEEP];
      o_fifo_en <= fctl_r[uirq_pkg::FC_FIFO_EN];
      o_dma_mode <= fctl_r[uirq_pkg::FC_DMA_MODE];
    end

  // =========================================================
  // transmit dma request: armed by free space, dropped by a write
  always_comb
  begin
    txq_nxt = txq_r;
    unique case (txq_r)
      uirq_pkg::TXR_IDLE:
        if (i_tx_fifo_empty && !hold_wr)
          txq_nxt = uirq_pkg::TXR_ACTIVE;
      uirq_pkg::TXR_ACTIVE:
        if (hold_wr)
          txq_nxt = uirq_pkg::TXR_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      txq_r <= uirq_pkg::TXR_IDLE;
    else
      txq_r <= txq_nxt;

  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      o_tx_dma_req_n <= 1'b1;
    else
      o_tx_dma_req_n <= (txq_nxt != uirq_pkg::TXR_ACTIVE);

  // =========================================================
  // receive dma request: low while the receiver holds data
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      o_rx_dma_req_n <= 1'b1;
    else
      o_rx_dma_req_n <= (i_rx_count == 7'h00);

endmodule

// ---- uirq_pkg.sv ----
// uirq_pkg: offsets, field positions, reset values and state codes
// for the per-channel interrupt mask and line status block.
// assumes a three-bit register address and an eight-bit data bus.
package uirq_pkg;

  // ==========================================================
  // register offsets on the channel's parallel port
  localparam logic [2:0] OFS_HOLD = 3'h0; // tx_hold_reg / rx_hold_reg
  localparam logic [2:0] OFS_IMASK = 3'h1; // interrupt_mask_reg
  localparam logic [2:0] OFS_FIFO = 3'h2; // fifo_ctl_reg / irq_ident_reg
  localparam logic [2:0] OFS_LSTAT = 3'h5; // line_stat_reg

  // ==========================================================
  // interrupt mask fields
  localparam int IM_RX_DMA_REQ_N = 0;
  localparam int IM_THRE = 1;
  localparam int IM_RLS = 2;
  localparam int IM_MSR = 3;
  localparam int IM_SLEEP = 4;
  localparam int IM_XOFF = 5;
  localparam int IM_RTS = 6;
  localparam int IM_CTS = 7;
  localparam logic [7:0] IM_LOW_MASK = 8'h0F; // always accessible bits
  localparam logic [7:0] IMASK_RST = 8'h00;

  // ==========================================================
  // fifo control fields
  localparam int FC_FIFO_EN = 0;
  localparam int FC_DMA_MODE = 3;
  localparam logic [7:0] FC_KEEP = 8'hF9; // reset bits self clear
  localparam logic [7:0] FCTL_RST = 8'h00;

  // ==========================================================
  // line status fields
  localparam int LS_DRDY = 0;
  localparam int LS_ERR_LO = 1; // overrun, parity, framing, break
  localparam int LS_THRE = 5;
  localparam int LS_TEMT = 6;
  localparam int LS_FERR = 7;
  localparam logic [7:0] LSTAT_RST = 8'h60;

  // ==========================================================
  // identification codes, bit 0 low while pending
  localparam logic [7:0] ID_NONE = 8'h01;
  localparam logic [7:0] ID_RLS = 8'h06;
  localparam logic [7:0] ID_RX_DMA_REQ_N = 8'h04;
  localparam logic [7:0] ID_THRE = 8'h02;
  localparam logic [7:0] ID_MSR = 8'h00;
  localparam logic [7:0] ID_XOFF = 8'h10;
  localparam logic [7:0] ID_FLOW = 8'h20;
  localparam logic [7:0] ID_FIFO_ON = 8'hC0;

  // edge catcher lanes
  localparam int EV_CTS = 0;
  localparam int EV_RTS = 1;
  localparam int EV_XOFF = 2;
  localparam int EV_W = 3;

  // transmit dma request states
  typedef enum logic [0:0] {
    TXR_IDLE = 1'b0,
    TXR_ACTIVE = 1'b1
  } uirq_txreq_t;

endpackage

// ---- uirq_lsr_if.sv ----
// uirq_lsr_if: carries line status inputs and the assembled status
// between the channel hub and the line status keeper.
// assumes both ends run on the same core clock.
`timescale 1ns/10ps
interface uirq_lsr_if;
  logic [3:0] err_set; // overrun, parity, framing, break pulses
  logic rd_clr; // line status read strobe
  logic data_rdy;
  logic tx_empty;
  logic tsr_empty;
  logic fifo_err;
  logic [7:0] lsr;
  modport hub (output err_set, rd_clr, data_rdy, tx_empty,
    tsr_empty, fifo_err, input lsr);
  modport stat (input err_set, rd_clr, data_rdy, tx_empty,
    tsr_empty, fifo_err, output lsr);
endinterface

// ---- uirq_edge.sv ----
// uirq_edge: sticky rising edge catchers, one lane per event.
// assumes inputs synchronous to the core clock.
`timescale 1ns/10ps
module uirq_edge
#(
  parameter int W = 3
)
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_lvl,
  input wire logic [W-1:0] i_clr,
  output logic [W-1:0] o_flag
);

  logic [W-1:0] prev_r;

  // =========================================================
  // previous level, ones at reset so a high line is no edge
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      prev_r <= '1;
    else
      prev_r <= i_lvl;

  // =========================================================
  // sticky flags, a new edge wins over a clear
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      o_flag <= '0;
    else
      o_flag <= (o_flag & ~i_clr) | (i_lvl & ~prev_r);

endmodule

// ---- uirq_lsr.sv ----
// uirq_lsr: keeps the line status register of one channel.
// assumes error pulses last one cycle and status levels are current.
`timescale 1ns/10ps
module uirq_lsr
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  uirq_lsr_if.stat ls
);

  logic [3:0] err_r;
  logic [7:0] lsr_r;

  // =========================================================
  // sticky receive errors, cleared by a status read
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      err_r <= '0;
    else if (ls.rd_clr)
      err_r <= ls.err_set; // set wins
    else
      err_r <= err_r | ls.err_set;

  // =========================================================
  // status word assembly
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      lsr_r <= uirq_pkg::LSTAT_RST;
    else
    begin
      lsr_r[uirq_pkg::LS_DRDY] <= ls.data_rdy;
      lsr_r[uirq_pkg::LS_ERR_LO +: 4] <= (ls.rd_clr ? 4'h0 : err_r)
        | ls.err_set;
      lsr_r[uirq_pkg::LS_THRE] <= ls.tx_empty;
      lsr_r[uirq_pkg::LS_TEMT] <= ls.tx_empty & ls.tsr_empty;
      lsr_r[uirq_pkg::LS_FERR] <= ls.fifo_err;
    end

  assign ls.lsr = lsr_r;

endmodule

// ---- uirq_props.sv ----
// uirq_props: port timing checks on the channel interrupt block.
// assumes it is bound to uirq_top and sees only its ports.
`timescale 1ns/10ps
module uirq_props
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic i_mode68,
  input wire logic i_enh_en,
  input wire logic i_msr_delta,
  input wire logic [6:0] i_rx_count,
  input wire logic [6:0] i_rx_trig,
  input wire logic i_tx_fifo_empty,
  input wire logic i_tsr_empty,
  input wire logic o_chan_irq_out,
  input wire logic o_irq_wor_oe,
  input wire logic o_tx_dma_req_n,
  input wire logic o_rx_dma_req_n,
  input wire logic o_sleep_en
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // helper state
  logic [7:0] sh_r;
  logic [2:0] ls_r;
  logic wr;
  logic rd;
  // decoded one-cycle strobes
  assign wr = !i_cs_n && !i_wr_n;
  assign rd = !i_cs_n && !i_rd_n;
  // shadow of the mask and of the status levels one cycle back
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sh_r <= 8'h00;
      ls_r <= 3'h6;
    end
    else
    begin
      if (wr && i_addr == 3'h1)
        sh_r <= i_enh_en ? i_wdata : {sh_r[7:4], i_wdata[3:0]};
      ls_r <= {i_tx_fifo_empty & i_tsr_empty, i_tx_fifo_empty,
        i_rx_count != 7'h00};
    end
  end
  // ==========================================================
  // assertions
  sleep_copy_a: assert property (wr && i_addr == 3'h1 && i_enh_en
    |=> ##1 o_sleep_en == $past(i_wdata[4], 2)) else $error("sleep bad");
  mask_hide_a: assert property (rd && i_addr == 3'h1 && !i_enh_en
    |=> o_rdata[7:4] == 4'h0) else $error("mask top bits visible");
  rx_req_a: assert property ($past(i_rstn)
    |-> o_rx_dma_req_n == ($past(i_rx_count) == 7'h00))
    else $error("rx request wrong");
  pin_mode_a: assert property (i_mode68 |=> !o_chan_irq_out)
    else $error("channel pin active in wire-or mode");
  msr_gate_a: assert property (!i_mode68 && sh_r[3] && i_msr_delta
    |=> o_chan_irq_out) else $error("modem irq missing");
  all_masked_a: assert property ($past(i_rstn) && $past(sh_r) == 8'h00
    |-> !o_chan_irq_out && !o_irq_wor_oe) else $error("masked irq seen");
  rx_trig_a: assert property (!i_mode68 && sh_r[0]
    && i_rx_trig != 7'h00 && i_rx_count >= i_rx_trig
    |=> o_chan_irq_out) else $error("rx trigger irq missing");
  thre_gate_a: assert property ((!i_mode68 && sh_r[1]
    && i_tx_fifo_empty) [*2] |=> o_chan_irq_out) else $error("thre irq");
  tx_high_a: assert property (wr && i_addr == 3'h0
    |=> o_tx_dma_req_n) else $error("tx request not released");
  tx_low_a: assert property (i_tx_fifo_empty && !(wr && i_addr == 3'h0)
    |=> !o_tx_dma_req_n) else $error("tx request not raised");
  lsr_read_a: assert property (rd && i_addr == 3'h5
    |=> {o_rdata[6:5], o_rdata[0]} == $past(ls_r)) else $error("status");
  // main scenarios
  cover property (wr && i_addr == 3'h1 && i_enh_en);
  cover property (o_irq_wor_oe);
  cover property (!o_tx_dma_req_n ##1 o_tx_dma_req_n);
endmodule
bind uirq_top uirq_props u_props (.i_core_clk, .i_rstn, .i_cs_n, .i_rd_n,
  .i_wr_n, .i_addr, .i_wdata, .o_rdata, .i_mode68, .i_enh_en, .i_msr_delta,
  .i_rx_count, .i_rx_trig, .i_tx_fifo_empty, .i_tsr_empty, .o_chan_irq_out,
  .o_irq_wor_oe, .o_tx_dma_req_n, .o_rx_dma_req_n, .o_sleep_en);

// ---- uirq_host.sv ----
// uirq_host: parallel bus host issuing one-cycle register strobes.
// assumes callers are aligned just after a rising clock edge.
`timescale 1ns/10ps
module uirq_host
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [2:0] o_addr,
  output logic [7:0] o_wdata
);
  // idle bus at time zero
  initial
  begin
    o_cs_n = 1'h1;
    o_rd_n = 1'h1;
    o_wr_n = 1'h1;
    o_addr = 3'h0;
    o_wdata = 8'h00;
  end
  // one access held to the taking edge, returns the read data
  task automatic access(input logic w, input logic [2:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge i_core_clk);
    #1;
    o_cs_n = 1'h0;
    o_wr_n = !w;
    o_rd_n = w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_core_clk);
    #1;
    q = i_rdata;
    o_cs_n = 1'h1;
    o_wr_n = 1'h1;
    o_rd_n = 1'h1;
    o_addr = ~a; // idle lines never hold the last value
    o_wdata = ~d;
  endtask
endmodule

// ---- uirq_tb.sv ----
// tb: self-checking bench for the channel interrupt block.
// assumes uirq_host as bus partner and uirq_props bound to the top.
`timescale 1ns/10ps
module tb;
  // ==========================================================
  // signals
  logic i_core_clk = 1'h0;
  logic i_rstn = 1'h0;
  logic i_cs_n, i_rd_n, i_wr_n;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, q, m;
  logic i_mode68 = 1'h0, i_enh_en = 1'h1, i_cts = 1'h0, i_rts = 1'h0;
  logic i_xoff_rx = 1'h0, i_msr_delta = 1'h0, i_rx_fifo_err = 1'h0;
  logic i_tx_fifo_empty = 1'h0, i_tsr_empty = 1'h0;
  logic [3:0] i_rx_err = 4'h0, stk;
  logic [6:0] i_rx_count = 7'h00, i_rx_trig = 7'h01;
  logic o_chan_irq_out, o_irq_wor_o, o_irq_wor_oe, o_tx_dma_req_n;
  logic o_rx_dma_req_n, o_sleep_en, o_fifo_en, o_dma_mode;
  int bad_count = 0, checks_done = 0, cyc = 0, seed = 43882, r, b;
  // ==========================================================
  // clock, design and bus host
  always #5 i_core_clk = ~i_core_clk;
  uirq_top u_dut (.i_core_clk, .i_rstn, .i_cs_n, .i_rd_n, .i_wr_n,
    .i_addr, .i_wdata, .o_rdata, .i_mode68, .i_enh_en, .i_cts, .i_rts,
    .i_xoff_rx, .i_msr_delta, .i_rx_err, .i_rx_fifo_err, .i_rx_count,
    .i_rx_trig, .i_tx_fifo_empty, .i_tsr_empty, .o_chan_irq_out,
    .o_irq_wor_o, .o_irq_wor_oe, .o_tx_dma_req_n, .o_rx_dma_req_n,
    .o_sleep_en, .o_fifo_en, .o_dma_mode);
  uirq_host u_host (.i_core_clk, .i_rdata(o_rdata), .o_cs_n(i_cs_n),
    .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_addr(i_addr), .o_wdata(i_wdata));
  // ==========================================================
  // helpers
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_host.access(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a);
    u_host.access(1'h0, a, 8'h00, q);
  endtask
  // raise or clear one interrupt source by mask bit number
  task automatic src(input int k, input logic v);
    case (k)
      0: i_rx_count = v ? i_rx_trig : i_rx_trig - 7'h01;
      1: i_tx_fifo_empty = v;
      2: if (v)
      begin
        i_rx_err[r[1:0]] = 1'h1;
        tick(1);
        i_rx_err = 4'h0;
      end
      3: i_msr_delta = v;
      5: i_xoff_rx = v;
      6: i_rts = v;
      7: i_cts = v;
      default: ;
    endcase
    if (!v && k > 4)
      rd(3'h2); // ident read drops the edge flags
    if (!v && k == 2)
      rd(3'h5); // status read drops the error bits
  endtask
  // cycle ceiling against hangs
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      summarize();
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge i_core_clk);
    #1;
    check("reset irq", {5'h00, o_chan_irq_out, o_irq_wor_oe, o_sleep_en},
      8'h00);
    i_rstn = 1'h1;
    rd(3'h1);
    check("mask reset", q, 8'h00);
    // random mask traffic with the enhanced gate toggling
    m = 8'h00;
    for (b = 0; b < 8; b++)
    begin
      r = $random(seed);
      i_enh_en = r[8];
      wr(3'h1, r[7:0]);
      m = i_enh_en ? r[7:0] : {m[7:4], r[3:0]};
      i_enh_en = r[9];
      rd(3'h1);
      check("mask", q, i_enh_en ? m : {4'h0, m[3:0]});
      check("sleep", {7'h00, o_sleep_en}, {7'h00, m[4]});
    end
    i_enh_en = 1'h1;
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h09);
    tick(1);
    check("fifo ctl", {6'h00, o_fifo_en, o_dma_mode}, 8'h03);
    wr(3'h2, 8'h01);
    // polled status with random levels and error pulses
    stk = 4'h0;
    for (b = 0; b < 16; b++)
    begin
      r = $random(seed);
      i_rx_count = {1'h0, r[5:0]};
      i_tx_fifo_empty = r[8];
      i_tsr_empty = r[9];
      i_rx_fifo_err = r[10];
      i_rx_err = r[14:11];
      tick(1);
      i_rx_err = 4'h0;
      stk = stk | r[14:11];
      tick(2);
      rd(3'h5);
      check("status", q, {i_rx_fifo_err, i_tx_fifo_empty & i_tsr_empty,
        i_tx_fifo_empty, stk, i_rx_count != 7'h00});
      stk = 4'h0;
    end
    i_rx_count = 7'h00;
    i_tx_fifo_empty = 1'h0;
    i_rx_fifo_err = 1'h0;
    i_rx_trig = 7'h01 + {1'h0, r[21:16]};
    // each source masked, then enabled, then cleared
    for (b = 0; b < 8; b++)
    begin
      if (b == 4)
        continue;
      src(b, 1'h1);
      tick(4);
      check("masked", {7'h00, o_chan_irq_out}, 8'h00);
      src(b, 1'h0);
      wr(3'h1, 8'h01 << b);
      src(b, 1'h1);
      tick(4);
      check("enabled", {7'h00, o_chan_irq_out}, 8'h01);
      if (b == 0)
        rd(3'h2);
      if (b == 0)
        check("ident", q, 8'hC4);
      src(b, 1'h0);
      tick(4);
      check("cleared", {7'h00, o_chan_irq_out}, 8'h00);
      wr(3'h1, 8'h00);
    end
    i_rx_count = 7'h00;
    // wire-or pin in the other bus mode
    i_mode68 = 1'h1;
    wr(3'h1, 8'h08);
    i_msr_delta = 1'h1;
    tick(4);
    check("wire-or", {5'h00, o_chan_irq_out, o_irq_wor_o, o_irq_wor_oe},
      8'h01);
    i_msr_delta = 1'h0;
    i_mode68 = 1'h0;
    // dma request pins
    i_rx_count = 7'h05;
    tick(2);
    check("rx req", {7'h00, o_rx_dma_req_n}, 8'h00);
    i_rx_count = 7'h00;
    tick(2);
    check("rx req", {7'h00, o_rx_dma_req_n}, 8'h01);
    i_tx_fifo_empty = 1'h1;
    tick(2);
    check("tx req", {7'h00, o_tx_dma_req_n}, 8'h00);
    wr(3'h0, r[7:0]);
    i_tx_fifo_empty = 1'h0;
    tick(2);
    check("tx req", {7'h00, o_tx_dma_req_n}, 8'h01);
    summarize();
  end
endmodule
